//--- shared/rsc_params.svh
// Register offsets, field positions, reset values and timing counts for the reset source block
`ifndef RSC_PARAMS_SVH
`define RSC_PARAMS_SVH

`define RSC_SMC_ADDR     8'hff
`define RSC_ROR_ADDR     8'hef

`define RSC_SMC_DIG_ON   7
`define RSC_SMC_DIG_TRIP 6
`define RSC_SMC_DIG_WARN 5
`define RSC_SMC_DIG_IE   4
`define RSC_SMC_BAT_ON   3
`define RSC_SMC_BAT_TRIP 2
`define RSC_SMC_BAT_WARN 1
`define RSC_SMC_BAT_IE   0

`define RSC_ROR_PIN      0
`define RSC_ROR_POWER    1
`define RSC_ROR_CLKLOSS  2
`define RSC_ROR_WDOG     3
`define RSC_ROR_CMP      5
`define RSC_ROR_FLASH    6

`define RSC_SMC_RESET    8'h80

`define RSC_CLK_HZ       10000000
`define RSC_MCD_TIME_US  100
`define RSC_MCD_CYCLES   ((`RSC_MCD_TIME_US * `RSC_CLK_HZ) / 1000000)
`define RSC_WDT_DIV      12
`define RSC_HOLD_CYCLES  4

`endif

//--- shared/rsc_pkg.sv
// Types for the reset source block
package rsc_pkg;
  typedef enum logic [1:0] {
    RSC_RUN,
    RSC_HOLD
  } rsc_state_t;
endpackage

//--- hw/rsc_reset_source.sv
// Reset source logic: supply monitor control, reset-origin flags and reset generation
`timescale 1ns/1ps
`default_nettype none
`include "rsc_params.svh"

module rsc_reset_source
  import rsc_pkg::*;
#(
  parameter int MCD_CYCLES  = `RSC_MCD_CYCLES,
  parameter int WDT_DIV     = `RSC_WDT_DIV,
  parameter int HOLD_CYCLES = `RSC_HOLD_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  input  wire logic       digital_above_trip,
  input  wire logic       digital_warn_ok,
  input  wire logic       battery_above_trip,
  input  wire logic       battery_warn_ok,
  input  wire logic       power_reset_flag,
  input  wire logic       reset_pin_in,
  output logic            reset_pin_out,
  output logic            reset_pin_oe_n,
  input  wire logic       low_power,
  input  wire logic       core_clock_mon,
  input  wire logic       cmp_noninv_lt_inv,
  input  wire logic       cmp_wake_en,
  input  wire logic       wdt_kick,
  input  wire logic       wdt_disable,
  input  wire logic [15:0] wdt_limit,
  input  wire logic       flash_write_beyond_lock,
  input  wire logic       code_read_beyond_lock,
  input  wire logic       branch_beyond_lock,
  input  wire logic       flash_security_block,
  input  wire logic       flash_write_attempt,
  output logic            sys_reset,
  output logic            warn_irq,
  output logic            wdt_tick
);

  //////////////////////////////////////////////////////////////////////////////
  // State

  logic [7:0]  smc_q, smc_d;           // Only bits 7,4,3,0 stored
  logic        mcd_en_q, mcd_en_d;
  logic        cmp_en_q, cmp_en_d;
  logic        wdt_en_q, wdt_en_d;
  logic [6:0]  flags_q, flags_d;       // Origin flags, power bit unused
  logic        stall_lvl_q, stall_lvl_d;
  logic [15:0] stall_cnt_q, stall_cnt_d;
  logic [3:0]  div_q, div_d;
  logic        tick_q, tick_d;
  logic [15:0] wdt_cnt_q, wdt_cnt_d;
  logic [7:0]  hold_q, hold_d;
  rsc_state_t  st_q, st_d;
  logic [7:0]  rdata_d;
  logic        irq_d;

  logic clk_stall, cmp_trip, wdt_trip, flash_trip, pin_trip;
  logic wr_ok, any_trip, leave_hold;

  //////////////////////////////////////////////////////////////////////////////
  // Reset causes

  assign pin_trip   = !reset_pin_in;
  assign clk_stall  = mcd_en_q && !low_power &&
                      (stall_cnt_q >= 16'(MCD_CYCLES));
  assign cmp_trip   = cmp_en_q && cmp_noninv_lt_inv &&
                      (!low_power || cmp_wake_en);
  assign wdt_trip   = wdt_en_q && !low_power && tick_q &&
                      (wdt_cnt_q >= wdt_limit);
  assign flash_trip = flash_write_beyond_lock || code_read_beyond_lock ||
                      branch_beyond_lock ||
                      flash_security_block ||
                      (flash_write_attempt && !smc_q[`RSC_SMC_DIG_ON]);

  // A held reset ignores bus writes, so a stray write cannot outlive it
  assign wr_ok      = (st_q == RSC_RUN);
  assign any_trip   = pin_trip || clk_stall || cmp_trip || wdt_trip || flash_trip;
  assign leave_hold = (st_q == RSC_HOLD) && !pin_trip && (hold_q == 8'h00);

  //////////////////////////////////////////////////////////////////////////////
  // Register writes

  always_comb begin
    smc_d    = smc_q;
    mcd_en_d = mcd_en_q;
    cmp_en_d = cmp_en_q;
    // Status bits are not stored; reads take them live from the monitors
    if (wr_ok && sfr_wr && (sfr_addr == `RSC_SMC_ADDR)) begin
      smc_d[`RSC_SMC_DIG_ON] = sfr_wdata[`RSC_SMC_DIG_ON];
      smc_d[`RSC_SMC_DIG_IE] = sfr_wdata[`RSC_SMC_DIG_IE];
      smc_d[`RSC_SMC_BAT_ON] = sfr_wdata[`RSC_SMC_BAT_ON];
      smc_d[`RSC_SMC_BAT_IE] = sfr_wdata[`RSC_SMC_BAT_IE];
    end
    if (wr_ok && sfr_wr && (sfr_addr == `RSC_ROR_ADDR)) begin
      mcd_en_d = sfr_wdata[`RSC_ROR_CLKLOSS];
      cmp_en_d = sfr_wdata[`RSC_ROR_CMP];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      smc_q    <= `RSC_SMC_RESET;
      mcd_en_q <= 1'b0;
      cmp_en_q <= 1'b0;
    end else if (clk_en) begin
      smc_q    <= smc_d;
      mcd_en_q <= mcd_en_d;
      cmp_en_q <= cmp_en_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Missing-clock detector

  always_comb begin
    // Samples the clock level; a stuck level counts up
    stall_lvl_d = core_clock_mon;
    stall_cnt_d = stall_cnt_q;
    // Saturates so a very long stall cannot wrap back to a short count
    if ((st_q == RSC_HOLD) || (core_clock_mon != stall_lvl_q)) begin
      stall_cnt_d = 16'h0000;
    end else if (stall_cnt_q != 16'hffff) begin
      stall_cnt_d = stall_cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stall_lvl_q <= 1'b0;
      stall_cnt_q <= 16'h0000;
    end else if (clk_en) begin
      stall_lvl_q <= stall_lvl_d;
      stall_cnt_q <= stall_cnt_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Watchdog

  always_comb begin
    // Divider runs even while reset is held, so the tick rate never drifts
    div_d  = div_q + 4'h1;
    tick_d = 1'b0;
    if (div_q == 4'(WDT_DIV - 1)) begin
      div_d  = 4'h0;
      tick_d = 1'b1;
    end
    wdt_en_d = wdt_en_q;
    if (leave_hold) begin
      wdt_en_d = 1'b1;
    end else if (wdt_disable) begin
      wdt_en_d = 1'b0;
    end
    wdt_cnt_d = wdt_cnt_q;
    // Cleared while reset is held, so a new run starts with a full allowance
    if ((st_q == RSC_HOLD) || wdt_kick || !wdt_en_q) begin
      wdt_cnt_d = 16'h0000;
    end else if (tick_q && !low_power) begin
      wdt_cnt_d = wdt_cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q     <= 4'h0;
      tick_q    <= 1'b0;
      wdt_en_q  <= 1'b1;
      wdt_cnt_q <= 16'h0000;
      wdt_tick  <= 1'b0;
    end else if (clk_en) begin
      div_q     <= div_d;
      tick_q    <= tick_d;
      wdt_en_q  <= wdt_en_d;
      wdt_cnt_q <= wdt_cnt_d;
      wdt_tick  <= tick_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Reset sequencer

  always_comb begin
    st_d    = st_q;
    hold_d  = hold_q;
    flags_d = flags_q;
    unique case (st_q)
      RSC_RUN: begin
        // Priority: pin, clock loss, comparator, watchdog, flash
        if (any_trip) begin
          flags_d = '0;
          if (pin_trip) begin
            flags_d[`RSC_ROR_PIN] = 1'b1;
          end else if (clk_stall) begin
            flags_d[`RSC_ROR_CLKLOSS] = 1'b1;
          end else if (cmp_trip) begin
            flags_d[`RSC_ROR_CMP] = 1'b1;
          end else if (wdt_trip) begin
            flags_d[`RSC_ROR_WDOG] = 1'b1;
          end else begin
            flags_d[`RSC_ROR_FLASH] = 1'b1;
          end
          st_d   = RSC_HOLD;
          hold_d = 8'(HOLD_CYCLES);
        end
      end
      RSC_HOLD: begin
        // Pin reset is held until the pin is released
        if (leave_hold) begin
          st_d = RSC_RUN;
        end else if (hold_q != 8'h00) begin
          hold_d = hold_q - 8'h01;
        end
      end
    endcase
  end

  // Flags survive internal resets; rst_n or the next trip, which keeps only the new cause, clears them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_q   <= '0;
      hold_q    <= 8'h00;
      st_q      <= RSC_RUN;
      sys_reset <= 1'b0;
    end else if (clk_en) begin
      flags_q   <= flags_d;
      hold_q    <= hold_d;
      st_q      <= st_d;
      sys_reset <= (st_d == RSC_HOLD);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read data and warning interrupt

  always_comb begin
    // Unmapped addresses read zero
    rdata_d = 8'h00;
    if (sfr_rd && (sfr_addr == `RSC_SMC_ADDR)) begin
      rdata_d = smc_q;
      rdata_d[`RSC_SMC_DIG_TRIP] = digital_above_trip;
      rdata_d[`RSC_SMC_DIG_WARN] = digital_warn_ok;
      rdata_d[`RSC_SMC_BAT_TRIP] = battery_above_trip;
      rdata_d[`RSC_SMC_BAT_WARN] = battery_warn_ok;
    end else if (sfr_rd && (sfr_addr == `RSC_ROR_ADDR)) begin
      // Power flag comes from the power-on logic; others then undefined
      rdata_d = {1'b0, flags_q[6:2], power_reset_flag, flags_q[0]};
    end
    irq_d = 1'b0;
    if (smc_q[`RSC_SMC_DIG_IE] && !digital_warn_ok) begin
      irq_d = 1'b1;
    end
    if (smc_q[`RSC_SMC_BAT_IE] && !battery_warn_ok) begin
      irq_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata <= 8'h00;
      warn_irq  <= 1'b0;
    end else if (clk_en) begin
      sfr_rdata <= rdata_d;
      warn_irq  <= irq_d;
    end
  end

  // Block never pulls the pin; supply resets that do lie outside this block
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reset_pin_out  <= 1'b1;
      reset_pin_oe_n <= 1'b1;
    end else if (clk_en) begin
      reset_pin_out  <= 1'b1;
      reset_pin_oe_n <= 1'b1;
    end
  end

endmodule
`default_nettype wire

//--- testbench/rsc_reset_source_monitor.sv
// Port checker for the reset source block
`timescale 1ns/1ps
`default_nettype none
module rsc_reset_source_monitor #(
  parameter int HOLD_CYCLES = 4
) (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       clk_en,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic       digital_warn_ok,
  input wire logic       battery_warn_ok,
  input wire logic       reset_pin_in,
  input wire logic       reset_pin_out,
  input wire logic       reset_pin_oe_n,
  input wire logic       low_power,
  input wire logic       cmp_wake_en,
  input wire logic       flash_write_beyond_lock,
  input wire logic       code_read_beyond_lock,
  input wire logic       branch_beyond_lock,
  input wire logic       flash_security_block,
  input wire logic       flash_write_attempt,
  input wire logic       sys_reset,
  input wire logic       warn_irq,
  input wire logic       wdt_tick
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] hold_q;
  logic [7:0] hold_d;
  logic       fl_any;
  // Counts how long the reset output has stood high
  always_comb hold_d = sys_reset ? hold_q + 8'h01 : 8'h00;
  always_ff @(posedge clk or negedge rst_n) hold_q <= !rst_n ? 8'h00 : hold_d;
  assign fl_any = flash_write_beyond_lock | code_read_beyond_lock | branch_beyond_lock
                | flash_security_block;
  a_pin_not_driven: assert property (reset_pin_oe_n && reset_pin_out)
    else $error("reset pin driven");
  a_pin_forces_reset: assert property (clk_en && !reset_pin_in |=> sys_reset)
    else $error("pin low without reset");
  a_release_pin_high: assert property ($fell(sys_reset) |-> $past(reset_pin_in))
    else $error("reset released while pin low");
  a_hold_length: assert property ($fell(sys_reset) |-> hold_q >= HOLD_CYCLES + 1)
    else $error("reset pulse too short");
  a_flash_fault: assert property (clk_en && !sys_reset && fl_any |=> sys_reset)
    else $error("flash fault without reset");
  a_sleep_quiet: assert property (clk_en && low_power && !cmp_wake_en && reset_pin_in
    && !sys_reset && !fl_any && !flash_write_attempt |=> !sys_reset)
    else $error("reset raised in low power");
  a_rdata_idle: assert property (!$past(sfr_rd) |-> sfr_rdata == 8'h00)
    else $error("read data without read");
  a_warn_cause: assert property (warn_irq |-> !(digital_warn_ok && battery_warn_ok
    && $past(digital_warn_ok) && $past(battery_warn_ok))) else $error("warning irq without cause");
  a_tick_spacing: assert property (wdt_tick |=> !wdt_tick [*8])
    else $error("watchdog tick too close");
  c_reset: cover property ($rose(sys_reset));
  c_warn: cover property (warn_irq);
  c_sleep: cover property (low_power && !sys_reset);
endmodule
bind rsc_reset_source rsc_reset_source_monitor #(.HOLD_CYCLES(HOLD_CYCLES)) u_rsc_reset_source_monitor (
  .clk, .rst_n, .clk_en, .sfr_rd, .sfr_rdata, .digital_warn_ok, .battery_warn_ok, .reset_pin_in,
  .reset_pin_out, .reset_pin_oe_n, .low_power, .cmp_wake_en, .flash_write_beyond_lock,
  .code_read_beyond_lock, .branch_beyond_lock, .flash_security_block, .flash_write_attempt,
  .sys_reset, .warn_irq, .wdt_tick);
`default_nettype wire

//--- testbench/rsc_pin_partner.sv
// External reset circuit pulling the reset pin low for a requested time
`timescale 1ns/1ps
`default_nettype none
module rsc_pin_partner (
  input  wire logic       clk,
  input  wire logic       start,
  input  wire logic [3:0] pulse_len,
  output logic            pin_low
);
  logic [3:0] cnt_q = 4'h0;
  always @(posedge clk) cnt_q <= start ? pulse_len : (cnt_q != 4'h0 ? cnt_q - 4'h1 : 4'h0);
  // Released pin falls back to the pull-up level
  assign pin_low = (cnt_q != 4'h0);
endmodule
`default_nettype wire

//--- testbench/rsc_reset_source_test.sv
// Self-checking bench for the reset source block
`timescale 1ns/1ps
`default_nettype none
module rsc_reset_source_test;
  logic clk = 1'b0, rst_n = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0, low_power = 1'b0, cmp = 1'b0;
  logic dtrip = 1'b1, dwarn = 1'b1, btrip = 1'b0, bwarn = 1'b0, mon = 1'b0, mon_run = 1'b1;
  logic kick = 1'b0, kick_on = 1'b1, pin_go = 1'b0;
  logic clk_en = 1'b1, pwr_flag = 1'b0, cmp_wake = 1'b0;
  wire logic wtick;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00;
  logic [4:0] fl = 5'h00;
  logic [3:0] pin_len = 4'h0;
  wire logic [7:0] sfr_rdata;
  wire logic pin_out, pin_oe_n, sys_reset, warn_irq, pin_low;
  wire logic pin = pin_low ? 1'b0 : (pin_oe_n ? 1'b1 : pin_out);
  int mismatches = 0, num_checks = 0, cyc = 0;
  always #50 clk = ~clk;
  always @(posedge clk) mon <= mon_run ? ~mon : mon;
  always @(posedge clk) kick <= kick_on && (cyc[4:0] == 5'h00);
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      complete_run();
    end
  end
  rsc_pin_partner u_rsc_pin_partner (.clk(clk), .start(pin_go), .pulse_len(pin_len),
    .pin_low(pin_low));
  rsc_reset_source #(.MCD_CYCLES(20), .WDT_DIV(12), .HOLD_CYCLES(4)) u_rsc_reset_source (
    .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .digital_above_trip(dtrip),
    .digital_warn_ok(dwarn), .battery_above_trip(btrip), .battery_warn_ok(bwarn),
    .power_reset_flag(pwr_flag), .reset_pin_in(pin), .reset_pin_out(pin_out),
    .reset_pin_oe_n(pin_oe_n), .low_power(low_power), .core_clock_mon(mon),
    .cmp_noninv_lt_inv(cmp), .cmp_wake_en(cmp_wake), .wdt_kick(kick), .wdt_disable(1'b0),
    .wdt_limit(16'h0010), .flash_write_beyond_lock(fl[0]), .code_read_beyond_lock(fl[1]),
    .branch_beyond_lock(fl[2]), .flash_security_block(fl[3]), .flash_write_attempt(fl[4]),
    .sys_reset(sys_reset), .warn_irq(warn_irq), .wdt_tick(wtick));
  ////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clk);
    sfr_rd <= 1'b0;
    #1 chk(sfr_rdata, exp);
  endtask
  // Bounded wait, since a missing reset must not hang the run
  task automatic rst_wait(input logic e);
    for (int n = 0; n < 400 && sys_reset !== e; n++) @(posedge clk) #1;
    chk({7'h00, sys_reset}, {7'h00, e});
  endtask
  task automatic t_regs();
    rd_chk(8'hff, 8'he0);
    rd_chk(8'h5a, 8'h00);
    wr(8'h5a, 8'hff);
    btrip <= 1'b1;
    bwarn <= 1'b1;
    wr(8'hff, 8'hff);
    rd_chk(8'hff, 8'hff);
    wr(8'hff, 8'h88);
    rd_chk(8'hff, 8'hee);
  endtask
  task automatic t_warn();
    wr(8'hff, 8'h98);
    dwarn <= 1'b0;
    dtrip <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk({7'h00, warn_irq}, 8'h01);
    rd_chk(8'hff, 8'h9e);
    wr(8'hff, 8'h88);
    repeat (3) @(posedge clk);
    #1 chk({7'h00, warn_irq}, 8'h00);
    @(posedge clk);
    dwarn <= 1'b1;
    dtrip <= 1'b1;
  endtask
  task automatic t_pin();
    @(posedge clk);
    low_power <= 1'b1;
    pin_len <= 4'h6;
    pin_go <= 1'b1;
    @(posedge clk);
    pin_go <= 1'b0;
    rst_wait(1'b1);
    @(posedge clk);
    low_power <= 1'b0;
    rst_wait(1'b0);
    rd_chk(8'hef, 8'h01);
  endtask
  task automatic t_flash();
    for (int i = 0; i < 5; i++) begin
      if (i == 4) wr(8'hff, 8'h08);
      @(posedge clk);
      fl <= 5'h01 << i;
      @(posedge clk);
      fl <= 5'h00;
      rst_wait(1'b1);
      rst_wait(1'b0);
      rd_chk(8'hef, 8'h40);
    end
    wr(8'hff, 8'h88);
  endtask
  task automatic t_clock();
    wr(8'hef, 8'h04);
    @(posedge clk);
    low_power <= 1'b1;
    mon_run <= 1'b0;
    repeat (60) @(posedge clk);
    #1 chk({7'h00, sys_reset}, 8'h00);
    @(posedge clk);
    low_power <= 1'b0;
    rst_wait(1'b1);
    @(posedge clk);
    mon_run <= 1'b1;
    rst_wait(1'b0);
    rd_chk(8'hef, 8'h04);
  endtask
  task automatic t_cmp_wdog();
    wr(8'hef, 8'h20);
    @(posedge clk);
    cmp <= 1'b1;
    rst_wait(1'b1);
    @(posedge clk);
    cmp <= 1'b0;
    rst_wait(1'b0);
    rd_chk(8'hef, 8'h20);
    @(posedge clk);
    kick_on <= 1'b0;
    rst_wait(1'b1);
    @(posedge clk);
    kick_on <= 1'b1;
    rst_wait(1'b0);
    rd_chk(8'hef, 8'h08);
  endtask
  // Comparator still enabled as reset source from the previous scenario
  task automatic t_sleep_cmp();
    @(posedge clk);
    low_power <= 1'b1;
    cmp <= 1'b1;
    repeat (10) @(posedge clk);
    #1 chk({7'h00, sys_reset}, 8'h00);
    @(posedge clk);
    cmp_wake <= 1'b1;
    rst_wait(1'b1);
    @(posedge clk);
    cmp <= 1'b0;
    cmp_wake <= 1'b0;
    low_power <= 1'b0;
    pwr_flag <= 1'b1;
    rst_wait(1'b0);
    rd_chk(8'hef, 8'h22);
    pwr_flag <= 1'b0;
  endtask
  task automatic t_freeze();
    int n;
    n = 0;
    repeat (120) begin
      @(posedge clk);
      #1 n += int'(wtick);
    end
    chk(8'(n), 8'h0a);
    @(posedge clk iff wtick);
    clk_en <= 1'b0;
    wr(8'hff, 8'h19);
    @(posedge clk);
    clk_en <= 1'b1;
    rd_chk(8'hff, 8'hee);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_warn();
    t_pin();
    t_flash();
    t_clock();
    t_cmp_wdog();
    t_sleep_cmp();
    t_freeze();
    complete_run();
  end
endmodule
`default_nettype wire
